// ### core/pus_params.svh
`ifndef PUS_PARAMS_SVH
`define PUS_PARAMS_SVH
// channel geometry
`define PUS_NUM_CH 8
`define PUS_VAL_W 16
`define PUS_ADR_W 8
// timing
`define PUS_CLK_NS 20
`define PUS_MS_NS 1000000
`define PUS_XFER_NS 1200000
// deviation arithmetic
`define PUS_AI_FULL 32'h0000FFFF
`define PUS_PCT_SCALE 32'h00000064
// peer update modes
`define PUS_MODE_OFF 2'h0
`define PUS_MODE_SINGLE 2'h1
`define PUS_MODE_MULTI 2'h2
// register byte offsets
`define PUS_REG_CTRL 8'h00
`define PUS_REG_STATUS 8'h04
`define PUS_REG_IRQ_MASK 8'h08
`define PUS_REG_PERIOD 8'h0C
`define PUS_REG_DEVIATION 8'h10
`define PUS_REG_CH_ENABLE 8'h14
`define PUS_REG_ANALOG_SEL 8'h18
`define PUS_REG_SINGLE_DEST 8'h1C
`define PUS_REG_FALL_MODE 8'h20
`define PUS_REG_FALL_DELAY 8'h24
`define PUS_REG_STATE 8'h28
`define PUS_REG_MAP_ADDR 8'h40
`define PUS_REG_MAP_CHAN 8'h60
`define PUS_MAP_SPAN 8'h20
// field positions
`define PUS_CTRL_MODE_LSB 0
`define PUS_CTRL_COS_BIT 2
`define PUS_ST_SENT 0
`define PUS_ST_COS 1
`define PUS_ST_REFUSED 2
`define PUS_ST_LATE 3
`define PUS_ST_W 4
// reset values
`define PUS_PERIOD_RST 16'h03E8
`define PUS_DEV_RST 8'h05
`define PUS_ENABLE_RST 8'hFF
`define PUS_DELAY_RST 16'h0064
`endif

// ### core/pus_peer_update.sv
`timescale 1ns/1ns
`include "pus_params.svh"
module pus_peer_update #(
  parameter int NUM_CH      = `PUS_NUM_CH,
  parameter int TICK_CYCLES = `PUS_MS_NS / `PUS_CLK_NS,
  parameter int XFER_CYCLES = `PUS_XFER_NS / `PUS_CLK_NS
) (
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  input  wire pus_pkg::pus_wb_req_type           wbReq,
  output logic [31:0]                            wbDatO,
  output logic                                   wbAck,
  input  wire logic [`PUS_NUM_CH-1:0]            diPins,
  input  wire logic [`PUS_NUM_CH*`PUS_VAL_W-1:0] aiValues,
  input  wire logic                              condLogicActive,
  output pus_pkg::pus_msg_type                   msgData,
  output logic                                   msgValid,
  input  wire logic                              msgReady,
  input  wire logic [`PUS_NUM_CH-1:0]            doCmd,
  output logic [`PUS_NUM_CH-1:0]                 doPins,
  output logic                                   irq
);
  import pus_pkg::*;

  localparam int NCH = `PUS_NUM_CH;
  localparam int VW  = `PUS_VAL_W;

  if (NUM_CH < 1 || NUM_CH > NCH || TICK_CYCLES < 1 || XFER_CYCLES < 2) begin : g_chk
    $error("pus_peer_update: unsupported parameter value");
  end

  function automatic logic [31:0] mergeBytes(logic [31:0] old, logic [31:0] nw,
                                             logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // percentage compare avoids a divider: diff*100 > pct*full
  function automatic logic changedBeyond(logic [VW-1:0] a, logic [VW-1:0] b,
                                         logic [7:0] pct, logic isAnalog);
    logic [VW-1:0] d;
    logic [31:0]   lhs;
    logic [31:0]   rhs;
    d   = (a > b) ? a - b : b - a;
    lhs = {16'h0000, d} * `PUS_PCT_SCALE;
    rhs = {24'h000000, pct} * `PUS_AI_FULL;
    return isAnalog ? (lhs > rhs) : (a != b);
  endfunction

  function automatic logic [2:0] lowestSet(logic [NCH-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // configuration and status
  logic [1:0]     mode;
  logic           cosEnable;
  logic [15:0]    periodMs;
  logic [7:0]     deviationPct;
  logic [NCH-1:0] chEnable;
  logic [NCH-1:0] analogSel;
  logic [31:0]    singleDest;
  logic [NCH-1:0] fallMode;
  logic [15:0]    fallDelayMs;
  logic [31:0]    mapAddr [NCH];
  logic [3:0]     mapChan [NCH];
  logic [`PUS_ST_W-1:0] status;
  logic [`PUS_ST_W-1:0] irqMask;

  // scheduling state
  pus_state_type  state;
  logic [NCH-1:0] diMeta;
  logic [NCH-1:0] diSync;
  logic [VW-1:0]  curVal  [NCH];
  logic [VW-1:0]  refVal  [NCH];
  logic [VW-1:0]  cmpRef  [NCH];
  logic [NCH-1:0] loadMask;
  logic [NCH-1:0] changeNow;
  logic [NCH-1:0] changeFlag;
  logic [NCH-1:0] pending;
  logic [NCH-1:0] sentMask;
  logic [31:0]    tickCnt;
  logic           msTick;
  logic [15:0]    periodCnt;
  logic           periodDue;
  logic [31:0]    sendCnt;
  logic           lateEvt;
  logic           refusedEvt;
  logic           msgTaken;
  logic           active;
  logic [15:0]    fallCnt [NCH];

  logic           busReq;
  logic           busWr;
  logic [31:0]    rdData;
  logic [`PUS_ST_W-1:0] next_status;

  assign busReq   = wbReq.cyc & wbReq.stb & ~wbAck;
  assign busWr    = busReq & wbReq.we;
  assign active   = (mode != `PUS_MODE_OFF);
  assign msgTaken = (state == SCH_SEND) & msgReady;
  assign irq      = |(status & irqMask);
  assign loadMask = (mode == `PUS_MODE_MULTI) ? NCH'(1) << lowestSet(pending) : chEnable;

  // inputs from pins cross in through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      diMeta <= '0;
      diSync <= '0;
    end else begin
      diMeta <= diPins;
      diSync <= diMeta;
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // at the take edge compare with the word in flight, else a sent change re-arms itself
      cmpRef[c] = (msgTaken && sentMask[c]) ? msgData.values[c*VW +: VW] : refVal[c];
      if (c < NUM_CH) begin
        curVal[c]    = analogSel[c] ? aiValues[c*VW +: VW] : {{(VW-1){1'b0}}, diSync[c]};
        changeNow[c] = changedBeyond(curVal[c], cmpRef[c], deviationPct, analogSel[c]);
      end else begin
        curVal[c]    = '0;
        changeNow[c] = 1'b0;
      end
    end
  end

  // millisecond enable and period timer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tickCnt <= '0;
      msTick  <= 1'b0;
    end else begin
      msTick  <= (tickCnt == 32'(TICK_CYCLES - 1));
      tickCnt <= (tickCnt == 32'(TICK_CYCLES - 1)) ? '0 : tickCnt + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      periodCnt <= '0;
      periodDue <= 1'b0;
    end else begin
      periodDue <= 1'b0;
      if (!active) begin
        periodCnt <= '0;
      end else if (msTick) begin
        if (periodCnt + 16'h0001 >= periodMs) begin
          periodCnt <= '0;
          periodDue <= 1'b1;
        end else begin
          periodCnt <= periodCnt + 16'h0001;
        end
      end
    end
  end

  // pending sends and change flags; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pending    <= '0;
      changeFlag <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!active || c >= NUM_CH) begin
          pending[c] <= 1'b0;
        end else if ((periodDue && chEnable[c]) ||
                     (cosEnable && changeNow[c] && chEnable[c])) begin
          pending[c] <= 1'b1;
        end else if (msgTaken && sentMask[c]) begin
          pending[c] <= 1'b0;
        end
        if (changeNow[c] && c < NUM_CH) begin
          changeFlag[c] <= 1'b1;
        end else if (msgTaken && sentMask[c]) begin
          changeFlag[c] <= 1'b0;
        end
      end
    end
  end

  // reference is the last value actually delivered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < NCH; c++) begin
        refVal[c] <= '0;
      end
    end else if (msgTaken) begin
      for (int c = 0; c < NCH; c++) begin
        if (sentMask[c]) begin
          refVal[c] <= msgData.values[c*VW +: VW];
        end
      end
    end
  end

  // message scheduler runs on its own once a mode is applied
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state    <= SCH_IDLE;
      msgValid <= 1'b0;
      msgData  <= '0;
      sentMask <= '0;
    end else begin
      case (state)
        SCH_IDLE: begin
          if (active && pending != '0) begin
            msgValid <= 1'b1;
            state    <= SCH_SEND;
            if (mode == `PUS_MODE_MULTI) begin
              sentMask               <= NCH'(1) << lowestSet(pending);
              msgData.destAddr       <= mapAddr[lowestSet(pending)];
              msgData.destChan       <= mapChan[lowestSet(pending)];
              msgData.multiDest      <= 1'b1;
              msgData.enables        <= NCH'(1) << lowestSet(pending);
              msgData.changed        <= changeFlag & (NCH'(1) << lowestSet(pending));
            end else begin
              sentMask               <= chEnable;
              msgData.destAddr       <= singleDest;
              msgData.destChan       <= 4'h0;
              msgData.multiDest      <= 1'b0;
              msgData.enables        <= chEnable;
              msgData.changed        <= changeFlag & chEnable;
            end
            for (int c = 0; c < NCH; c++) begin
              msgData.values[c*VW +: VW] <= loadMask[c] ? curVal[c] : '0;
            end
          end
        end
        SCH_SEND: begin
          if (msgReady) begin
            msgValid <= 1'b0;
            state    <= SCH_IDLE;
          end
        end
        default: begin
          msgValid <= 1'b0;
          state    <= SCH_IDLE;
        end
      endcase
    end
  end

  // flags a message the network has held past the transfer budget
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sendCnt <= '0;
      lateEvt <= 1'b0;
    end else begin
      lateEvt <= 1'b0;
      if (state != SCH_SEND) begin
        sendCnt <= '0;
      end else begin
        sendCnt <= sendCnt + 32'h00000001;
        lateEvt <= (sendCnt == 32'(XFER_CYCLES - 1));
      end
    end
  end

  // falling-delay outputs; the delay counts whole milliseconds
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      doPins <= '0;
      for (int c = 0; c < NCH; c++) begin
        fallCnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!fallMode[c] || doCmd[c] || !doPins[c]) begin
          doPins[c]  <= doCmd[c];
          fallCnt[c] <= '0;
        end else if (msTick) begin
          if (fallCnt[c] + 16'h0001 >= fallDelayMs) begin
            doPins[c]  <= 1'b0;
            fallCnt[c] <= '0;
          end else begin
            fallCnt[c] <= fallCnt[c] + 16'h0001;
          end
        end
      end
    end
  end

  // control register; a non-off mode write is refused while condLogicActive, other mode writes take effect when written
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode       <= `PUS_MODE_OFF;
      cosEnable  <= 1'b0;
      refusedEvt <= 1'b0;
    end else begin
      refusedEvt <= 1'b0;
      if (busWr && wbReq.adr == `PUS_REG_CTRL && wbReq.sel[0]) begin
        cosEnable <= wbReq.dat[`PUS_CTRL_COS_BIT];
        if (wbReq.dat[`PUS_CTRL_MODE_LSB +: 2] != `PUS_MODE_OFF && condLogicActive) begin
          refusedEvt <= 1'b1;
        end else if (wbReq.dat[`PUS_CTRL_MODE_LSB +: 2] == `PUS_MODE_MULTI) begin
          mode <= `PUS_MODE_MULTI;
        end else begin
          mode <= wbReq.dat[`PUS_CTRL_MODE_LSB] ? `PUS_MODE_SINGLE : `PUS_MODE_OFF;
        end
      end
    end
  end

  // remaining configuration; the whole map is plain storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqMask      <= '0;
      periodMs     <= `PUS_PERIOD_RST;
      deviationPct <= `PUS_DEV_RST;
      chEnable     <= `PUS_ENABLE_RST;
      analogSel    <= '0;
      singleDest   <= '0;
      fallMode     <= '0;
      fallDelayMs  <= `PUS_DELAY_RST;
      for (int c = 0; c < NCH; c++) begin
        mapAddr[c] <= '0;
        mapChan[c] <= '0;
      end
    end else if (busWr) begin
      case (wbReq.adr)
        `PUS_REG_IRQ_MASK: irqMask <= `PUS_ST_W'(mergeBytes(32'(irqMask), wbReq.dat, wbReq.sel));
        `PUS_REG_PERIOD: periodMs <= 16'(mergeBytes(32'(periodMs), wbReq.dat, wbReq.sel));
        `PUS_REG_DEVIATION: deviationPct <= 8'(mergeBytes(32'(deviationPct), wbReq.dat,
                                                         wbReq.sel));
        `PUS_REG_CH_ENABLE: chEnable <= NCH'(mergeBytes(32'(chEnable), wbReq.dat, wbReq.sel));
        `PUS_REG_ANALOG_SEL: analogSel <= NCH'(mergeBytes(32'(analogSel), wbReq.dat, wbReq.sel));
        `PUS_REG_SINGLE_DEST: singleDest <= mergeBytes(singleDest, wbReq.dat, wbReq.sel);
        `PUS_REG_FALL_MODE: fallMode <= NCH'(mergeBytes(32'(fallMode), wbReq.dat, wbReq.sel));
        `PUS_REG_FALL_DELAY: fallDelayMs <= 16'(mergeBytes(32'(fallDelayMs), wbReq.dat,
                                                          wbReq.sel));
        default: begin
          if (wbReq.adr >= `PUS_REG_MAP_ADDR && wbReq.adr < `PUS_REG_MAP_CHAN) begin
            mapAddr[wbReq.adr[4:2]] <= mergeBytes(mapAddr[wbReq.adr[4:2]], wbReq.dat,
                                                  wbReq.sel);
          end else if (wbReq.adr >= `PUS_REG_MAP_CHAN &&
                       wbReq.adr < `PUS_REG_MAP_CHAN + `PUS_MAP_SPAN) begin
            mapChan[wbReq.adr[4:2]] <= 4'(mergeBytes(32'(mapChan[wbReq.adr[4:2]]),
                                                     wbReq.dat, wbReq.sel));
          end
        end
      endcase
    end
  end

  // sticky events, write one to clear
  always_comb begin
    next_status = status;
    if (busWr && wbReq.adr == `PUS_REG_STATUS && wbReq.sel[0]) begin
      next_status = status & ~wbReq.dat[`PUS_ST_W-1:0];
    end
    next_status[`PUS_ST_SENT]    = next_status[`PUS_ST_SENT] | msgTaken;
    next_status[`PUS_ST_COS]     = next_status[`PUS_ST_COS] | (active & cosEnable &
                                   |(changeNow & chEnable & ~changeFlag));
    next_status[`PUS_ST_REFUSED] = next_status[`PUS_ST_REFUSED] | refusedEvt;
    next_status[`PUS_ST_LATE]    = next_status[`PUS_ST_LATE] | lateEvt;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_comb begin
    rdData = 32'h00000000;
    case (wbReq.adr)
      `PUS_REG_CTRL: rdData = {29'h00000000, cosEnable, mode};
      `PUS_REG_STATUS: rdData = 32'(status);
      `PUS_REG_IRQ_MASK: rdData = 32'(irqMask);
      `PUS_REG_PERIOD: rdData = 32'(periodMs);
      `PUS_REG_DEVIATION: rdData = 32'(deviationPct);
      `PUS_REG_CH_ENABLE: rdData = 32'(chEnable);
      `PUS_REG_ANALOG_SEL: rdData = 32'(analogSel);
      `PUS_REG_SINGLE_DEST: rdData = singleDest;
      `PUS_REG_FALL_MODE: rdData = 32'(fallMode);
      `PUS_REG_FALL_DELAY: rdData = 32'(fallDelayMs);
      `PUS_REG_STATE: rdData = {6'h00, msgValid, active, pending, changeFlag, diSync};
      default: begin
        if (wbReq.adr >= `PUS_REG_MAP_ADDR && wbReq.adr < `PUS_REG_MAP_CHAN) begin
          rdData = mapAddr[wbReq.adr[4:2]];
        end else if (wbReq.adr >= `PUS_REG_MAP_CHAN &&
                     wbReq.adr < `PUS_REG_MAP_CHAN + `PUS_MAP_SPAN) begin
          rdData = 32'(mapChan[wbReq.adr[4:2]]);
        end
      end
    endcase
  end

  // one wait state; unmapped words read zero and still acknowledge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wbAck  <= 1'b0;
      wbDatO <= '0;
    end else begin
      wbAck <= busReq;
      if (busReq && !wbReq.we) begin
        wbDatO <= rdData;
      end
    end
  end
endmodule

// ### core/pus_pkg.sv
`include "pus_params.svh"
package pus_pkg;
  typedef struct packed {
    logic                    cyc;
    logic                    stb;
    logic                    we;
    logic [`PUS_ADR_W-1:0]   adr;
    logic [3:0]              sel;
    logic [31:0]             dat;
  } pus_wb_req_type;

  typedef struct packed {
    logic [31:0]                       destAddr;
    logic [3:0]                        destChan;
    logic                              multiDest;
    logic [`PUS_NUM_CH-1:0]            enables;
    logic [`PUS_NUM_CH-1:0]            changed;
    logic [`PUS_NUM_CH*`PUS_VAL_W-1:0] values;
  } pus_msg_type;

  typedef enum logic {SCH_IDLE, SCH_SEND} pus_state_type;
endpackage

// ### tb/pus_net_peer.sv
`timescale 1ns/1ns
module pus_net_peer (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       msgValid,
  input wire logic [7:0] stall,
  output logic           msgReady
);
  logic [7:0] waitCnt;
  // takes every message on its own after a set stall, no controller involved
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      waitCnt  <= '0;
      msgReady <= 1'b0;
    end else if (msgValid && msgReady) begin
      waitCnt  <= '0;
      msgReady <= 1'b0;
    end else if (msgValid) begin
      if (waitCnt >= stall) msgReady <= 1'b1;
      else waitCnt <= waitCnt + 8'h01;
    end
  end
endmodule

// ### tb/pus_peer_update_monitor.sv
`timescale 1ns/1ns
`include "pus_params.svh"
module pus_peer_update_monitor (
  input wire logic                             clk_sys,
  input wire logic                             nrst,
  input wire pus_pkg::pus_wb_req_type          wbReq,
  input wire logic                             wbAck,
  input wire logic                             condLogicActive,
  input wire pus_pkg::pus_msg_type             msgData,
  input wire logic                             msgValid,
  input wire logic                             msgReady,
  input wire logic [`PUS_NUM_CH-1:0]           doCmd,
  input wire logic [`PUS_NUM_CH-1:0]           doPins,
  input wire logic                             irq
);
  import pus_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic         modeOn;
  logic [127:0] valMask;
  always_comb begin
    for (int c = 0; c < 8; c++) valMask[c*16+:16] = {16{msgData.enables[c]}};
  end
  // a refused mode write leaves the previous mode in force
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) modeOn <= 1'b0;
    else if (wbReq.cyc && wbReq.stb && wbReq.we && !wbAck && wbReq.sel[0]
             && wbReq.adr == `PUS_REG_CTRL && !condLogicActive)
      modeOn <= |wbReq.dat[1:0];
  end
  chk_rise_cmd: assert property ((doPins & ~$past(doPins) & ~$past(doCmd)) == '0)
    else $error("output rose without command");
  chk_fall_cmd: assert property ((~doPins & $past(doPins) & $past(doCmd)) == '0)
    else $error("output fell while commanded high");
  chk_mask_zero: assert property (msgValid |-> (msgData.values & ~valMask) == '0)
    else $error("masked channel value not zero");
  chk_multi_onehot: assert property (msgValid && msgData.multiDest |-> $onehot(msgData.enables))
    else $error("multi message not one channel");
  chk_chg_masked: assert property (msgValid |-> (msgData.changed & ~msgData.enables) == '0)
    else $error("change flag on unmapped channel");
  chk_msg_hold: assert property (msgValid && !msgReady |=> msgValid && $stable(msgData))
    else $error("message dropped or changed before taken");
  chk_msg_gap: assert property (msgValid && msgReady |=> !msgValid)
    else $error("no gap after message taken");
  chk_mode_first: assert property ($rose(msgValid) |-> modeOn)
    else $error("message while peer update off");
  chk_ack_pulse: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("bus ack not one cycle");
  cover property (msgValid && msgReady && msgData.multiDest);
  cover property (msgValid && msgReady && |msgData.changed);
  cover property ($rose(irq));
  cover property ($fell(doPins[0]));
endmodule
bind pus_peer_update pus_peer_update_monitor mon (.clk_sys(clk_sys), .nrst(nrst),
  .wbReq(wbReq), .wbAck(wbAck), .condLogicActive(condLogicActive), .msgData(msgData),
  .msgValid(msgValid), .msgReady(msgReady), .doCmd(doCmd), .doPins(doPins), .irq(irq));

// ### tb/pus_peer_update_tb.sv
`timescale 1ns/1ns
`include "pus_params.svh"
module pus_peer_update_tb;
  import pus_pkg::*;
  typedef struct packed {pus_msg_type m; logic chg;} pus_exp_type;
  logic           clk_sys, nrst, condLogicActive, msgValid, msgReady, wbAck, irq;
  pus_wb_req_type wbReq;
  pus_msg_type    msgData;
  logic [31:0]    wbDatO, dest;
  logic [7:0]     diPins, doCmd, doPins, stall, lastEn, anaSel;
  logic [127:0]   aiValues;
  int             bad_count, check_count, takeCnt, cycles, n, k;
  logic [31:0]    rdQ[$];
  pus_exp_type    msgQ[$];
  logic [7:0]     ra[6] = '{`PUS_REG_CTRL, `PUS_REG_PERIOD, `PUS_REG_DEVIATION,
                            `PUS_REG_CH_ENABLE, `PUS_REG_FALL_DELAY, 8'h3C};
  logic [31:0]    rv[6] = '{32'h0, 32'h3E8, 32'h5, 32'hFF, 32'h64, 32'h0};

  pus_peer_update #(.TICK_CYCLES(10), .XFER_CYCLES(50)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .diPins(diPins), .aiValues(aiValues),
    .condLogicActive(condLogicActive), .msgData(msgData), .msgValid(msgValid),
    .msgReady(msgReady), .doCmd(doCmd), .doPins(doPins), .irq(irq));
  pus_net_peer peer (.clk_sys(clk_sys), .nrst(nrst), .msgValid(msgValid), .stall(stall),
    .msgReady(msgReady));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic cmp(input string what, input logic [191:0] e, input logic [191:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // single-mode channel number is not defined, so it is not compared
  task automatic chkMsg(input pus_exp_type x);
    pus_msg_type s;
    s = msgData;
    if (!x.chg) s.changed = x.m.changed;
    if (!x.m.multiDest) s.destChan = x.m.destChan;
    cmp("message", x.m, s);
  endtask

  function automatic pus_msg_type mk(input logic [31:0] da, input logic [3:0] dc,
                                     input logic mu, input logic [7:0] en, input logic [7:0] ch);
    mk = '0;
    mk.destAddr = da;
    mk.destChan = dc;
    mk.multiDest = mu;
    mk.enables = en;
    mk.changed = ch;
    for (int c = 0; c < 8; c++)
      if (en[c]) mk.values[c*16+:16] = anaSel[c] ? aiValues[c*16+:16] : {15'h0, diPins[c]};
  endfunction

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    wbReq <= '{1'b1, 1'b1, w, a, 4'hF, d};
    @(posedge clk_sys);
    while (wbAck !== 1'b1) @(posedge clk_sys);
    wbReq <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    wb(a, 1'b0, 32'h0);
  endtask

  task automatic waitTake(input int lim, input logic exp);
    int t0;
    t0 = takeCnt;
    repeat (lim) begin
      @(negedge clk_sys);
      if (takeCnt != t0) break;
    end
    cmp("take", exp, takeCnt != t0);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
    if (wbAck === 1'b1 && wbReq.we === 1'b0 && rdQ.size() > 0) cmp("rdata", rdQ.pop_front(), wbDatO);
    if (msgValid === 1'b1 && msgReady === 1'b1) begin
      takeCnt++;
      lastEn = msgData.enables;
      if (msgQ.size() > 0) chkMsg(msgQ.pop_front());
    end
  end

  initial begin
    k = $urandom(32'h7A675542);
    nrst = 1'b0;
    wbReq = '0;
    diPins = '0;
    aiValues = '0;
    condLogicActive = 1'b0;
    doCmd = '0;
    stall = '0;
    anaSel = '0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (n = 0; n < 6; n++) rd(ra[n], rv[n]);
    $display("test reset values done");
    condLogicActive <= 1'b1;
    wb(`PUS_REG_CTRL, 1'b1, 32'h1);
    rd(`PUS_REG_CTRL, 32'h0);
    rd(`PUS_REG_STATUS, 32'h4);
    @(negedge clk_sys);
    cmp("irq", 1'b0, irq);
    wb(`PUS_REG_IRQ_MASK, 1'b1, 32'h4);
    @(negedge clk_sys);
    cmp("irq", 1'b1, irq);
    wb(`PUS_REG_STATUS, 1'b1, 32'h4);
    @(negedge clk_sys);
    cmp("irq", 1'b0, irq);
    wb(`PUS_REG_IRQ_MASK, 1'b1, 32'h0);
    condLogicActive <= 1'b0;
    $display("test refusal done");
    dest = $urandom;
    diPins <= $urandom;
    stall <= $urandom_range(3);
    wb(`PUS_REG_PERIOD, 1'b1, 32'h2);
    wb(`PUS_REG_SINGLE_DEST, 1'b1, dest);
    wb(`PUS_REG_CH_ENABLE, 1'b1, 32'h0F);
    wb(`PUS_REG_CTRL, 1'b1, 32'h1);
    waitTake(100, 1'b1);
    msgQ.push_back('{mk(dest, 4'h0, 1'b0, 8'h0F, 8'h00), 1'b1});
    waitTake(100, 1'b1);
    $display("test single periodic done");
    wb(`PUS_REG_PERIOD, 1'b1, 32'hC8);
    wb(`PUS_REG_CH_ENABLE, 1'b1, 32'hFF);
    aiValues[112+:16] <= $urandom_range(32'h7FFF);
    anaSel = 8'h80;
    wb(`PUS_REG_ANALOG_SEL, 1'b1, 32'h80);
    wb(`PUS_REG_CTRL, 1'b1, 32'h5);
    repeat (60) @(posedge clk_sys);
    k = $urandom_range(3);
    diPins <= diPins ^ (8'h01 << k);
    @(negedge clk_sys);
    msgQ.push_back('{mk(dest, 4'h0, 1'b0, 8'hFF, 8'h01 << k), 1'b1});
    waitTake(20, 1'b1);
    @(posedge clk_sys);
    aiValues[112+:16] <= aiValues[112+:16] + 16'h2000;
    @(negedge clk_sys);
    msgQ.push_back('{mk(dest, 4'h0, 1'b0, 8'hFF, 8'h80), 1'b1});
    waitTake(20, 1'b1);
    @(posedge clk_sys);
    aiValues[112+:16] <= aiValues[112+:16] + 16'h0100;
    waitTake(40, 1'b0);
    $display("test change trigger done");
    stall <= $urandom_range(6);
    for (n = 0; n < 8; n++) begin
      wb(`PUS_REG_MAP_ADDR + 8'(4 * n), 1'b1, dest + n);
      wb(`PUS_REG_MAP_CHAN + 8'(4 * n), 1'b1, 32'(7 - n));
    end
    wb(`PUS_REG_CH_ENABLE, 1'b1, 32'h06);
    anaSel = 8'h00;
    wb(`PUS_REG_ANALOG_SEL, 1'b1, 32'h0);
    // long period so a pair never straddles the next period edge
    wb(`PUS_REG_PERIOD, 1'b1, 32'h5);
    wb(`PUS_REG_CTRL, 1'b1, 32'h2);
    do waitTake(100, 1'b1); while (lastEn !== 8'h04);
    msgQ.push_back('{mk(dest + 1, 4'h6, 1'b1, 8'h02, 8'h00), 1'b0});
    msgQ.push_back('{mk(dest + 2, 4'h5, 1'b1, 8'h04, 8'h00), 1'b0});
    waitTake(100, 1'b1);
    waitTake(100, 1'b1);
    $display("test multi destination done");
    wb(`PUS_REG_FALL_MODE, 1'b1, 32'h1);
    wb(`PUS_REG_FALL_DELAY, 1'b1, 32'h3);
    doCmd <= 8'h03;
    repeat (3) @(negedge clk_sys);
    cmp("outputs", 8'h03, doPins);
    @(posedge clk_sys);
    doCmd <= 8'h00;
    repeat (15) @(negedge clk_sys);
    cmp("outputs", 8'h01, doPins);
    repeat (40) @(negedge clk_sys);
    cmp("outputs", 8'h00, doPins);
    $display("test falling delay done");
    stall <= 8'h3C;
    waitTake(200, 1'b1);
    wb(`PUS_REG_STATUS, 1'b1, 32'hF);
    waitTake(200, 1'b1);
    rd(`PUS_REG_STATUS, 32'h9);
    $display("test transfer budget done");
    conclude();
  end
endmodule
